// ---- logic/bhac_map.svh ----
`ifndef BHAC_MAP_SVH
`define BHAC_MAP_SVH

// bus widths
`define BHAC_ADDR_W 32
`define BHAC_DATA_W 32
`define BHAC_FC_W 3
`define BHAC_SIZE_W 2

// synchroniser depth for bus request and grant acknowledge (two flops)
`define BHAC_SYNC_W 2

// status pulse length code width and longest pulse in clocks
`define BHAC_STAT_W 2
`define BHAC_STAT_MAX 2'd3

// reset values
`define BHAC_RST_ADDR 32'h0000_0000
`define BHAC_RST_DATA 32'h0000_0000
`define BHAC_RST_FC 3'h0
`define BHAC_RST_SIZE 2'h0

`endif

// ---- logic/bhac_pkg.sv ----
package bhac_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_RUN,
    BUS_RETRY,
    BUS_HALTED
  } bhac_bus_state_type;

  typedef enum logic [2:0] {
    ARB_OWN,
    ARB_GRANT,
    ARB_GRANT_HOLD,
    ARB_RELEASE,
    ARB_FOREIGN
  } bhac_arb_state_type;

  // one external access as latched at cycle start
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] fc;
    logic [1:0] size;
    logic rw;
    logic [31:0] wdata;
  } bhac_access_type;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    bhac_bus_state_type bus;
    bhac_arb_state_type arb;
    bhac_access_type acc;
    logic lock;
    logic dbl;
    logic [1:0] stat_cnt;
    logic status;
    logic strobe_n;
    logic ctrl_oe_n;
    logic addr_oe_n;
    logic data_oe_n;
    logic grant;
    logic done;
    logic err;
    logic [31:0] rdata;
    logic nop_stall;
    logic irq_ok;
    logic irq_pend;
  } bhac_state_type;

endpackage

// ---- logic/bhac_bus_ctrl.sv ----
`timescale 1ns/1ps
`include "bhac_map.svh"

module bhac_bus_ctrl (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // core side
  input wire logic core_reset_i,
  input wire logic cyc_req_i,
  input wire logic [`BHAC_ADDR_W-1:0] cyc_addr_i,
  input wire logic [`BHAC_FC_W-1:0] cyc_fc_i,
  input wire logic [`BHAC_SIZE_W-1:0] cyc_size_i,
  input wire logic cyc_rw_i,
  input wire logic cyc_locked_i,
  input wire logic [`BHAC_DATA_W-1:0] cyc_wdata_i,
  output logic cyc_done_o,
  output logic cyc_err_o,
  output logic [`BHAC_DATA_W-1:0] cyc_rdata_o,
  // exception, instruction and status side
  input wire logic exc_active_i,
  input wire logic addr_err_i,
  input wire logic nop_i,
  output logic nop_stall_o,
  input wire logic [`BHAC_STAT_W-1:0] status_len_i,
  output logic status_o,
  input wire logic irq_pending_i,
  output logic irq_service_ok_o,
  output logic interrupt_pending_out_o,
  // bus cycle pins
  input wire logic halt_req_i,
  input wire logic bus_fault_in_i,
  input wire logic term_ack_i,
  input wire logic [`BHAC_DATA_W-1:0] data_i,
  output logic [`BHAC_ADDR_W-1:0] addr_o,
  output logic [`BHAC_FC_W-1:0] fc_o,
  output logic [`BHAC_SIZE_W-1:0] size_o,
  output logic rw_o,
  output logic addr_oe_n_o,
  output logic address_strobe_n_o,
  output logic locked_cycle_indicator_n_o,
  output logic ctrl_oe_n_o,
  output logic [`BHAC_DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  // arbitration pins
  input wire logic bus_request_in_i,
  input wire logic grant_acknowledge_in_i,
  output logic bus_grant_out_o
);

  bhac_pkg::bhac_state_type s_q;
  bhac_pkg::bhac_state_type s_d;

  logic req_s;
  logic ack_s;
  logic start_now;

  assign req_s = s_q.sync2[1];
  assign ack_s = s_q.sync2[0];
  // a cycle is only begun while the arbiter owns the bus outright
  assign start_now = (s_q.bus == bhac_pkg::BUS_IDLE) && cyc_req_i && !halt_req_i
                     && !s_q.dbl && (s_q.arb == bhac_pkg::ARB_OWN) && !core_reset_i;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d = s_q;
    // first stage feeds only the second stage
    s_d.sync1 = {bus_request_in_i, grant_acknowledge_in_i};
    s_d.sync2 = s_q.sync1;
    s_d.done = 1'b0;
    s_d.err = 1'b0;

    unique case (s_q.bus)
      bhac_pkg::BUS_IDLE: begin
        s_d.lock = cyc_locked_i && cyc_req_i;
        if (start_now) begin
          s_d.acc.addr = cyc_addr_i;
          s_d.acc.fc = cyc_fc_i;
          s_d.acc.size = cyc_size_i;
          s_d.acc.rw = cyc_rw_i;
          s_d.acc.wdata = cyc_wdata_i;
          s_d.bus = bhac_pkg::BUS_RUN;
        end
      end
      bhac_pkg::BUS_RUN: begin
        // halt alone never terminates; only fault, acknowledge or core reset do
        if (bus_fault_in_i && halt_req_i) begin
          s_d.bus = bhac_pkg::BUS_RETRY;
        end else if (bus_fault_in_i) begin
          s_d.err = 1'b1;
          s_d.bus = bhac_pkg::BUS_IDLE;
          if (exc_active_i) begin
            s_d.dbl = 1'b1;
          end
        end else if (term_ack_i) begin
          s_d.done = 1'b1;
          s_d.rdata = data_i;
          // one cycle then stop again: single step from halt toggling
          s_d.bus = halt_req_i ? bhac_pkg::BUS_HALTED : bhac_pkg::BUS_IDLE;
        end
      end
      bhac_pkg::BUS_RETRY: begin
        // same access info is reused; lock stays asserted meanwhile
        if (!halt_req_i && (s_q.arb == bhac_pkg::ARB_OWN) && !s_q.dbl) begin
          s_d.bus = bhac_pkg::BUS_RUN;
        end
      end
      bhac_pkg::BUS_HALTED: begin
        if (!halt_req_i) begin
          s_d.bus = bhac_pkg::BUS_IDLE;
        end
      end
    endcase

    if (addr_err_i && exc_active_i) begin
      s_d.dbl = 1'b1;
    end

    // core reset restarts the sequencer but leaves the arbiter running
    if (core_reset_i) begin
      s_d.bus = bhac_pkg::BUS_IDLE;
      s_d.dbl = 1'b0;
      s_d.lock = 1'b0;
    end

    // arbiter: the processor yields the bus except during a locked sequence
    unique case (s_q.arb)
      bhac_pkg::ARB_OWN: begin
        // a cycle decided this clock goes out first, grant follows
        if (req_s && !s_q.lock && !start_now) begin
          s_d.arb = bhac_pkg::ARB_GRANT;
        end else if (ack_s) begin
          s_d.arb = bhac_pkg::ARB_FOREIGN;
        end
      end
      bhac_pkg::ARB_GRANT: begin
        s_d.arb = bhac_pkg::ARB_GRANT_HOLD;
      end
      bhac_pkg::ARB_GRANT_HOLD: begin
        if (ack_s || !req_s) begin
          s_d.arb = bhac_pkg::ARB_RELEASE;
        end
      end
      bhac_pkg::ARB_RELEASE: begin
        s_d.arb = bhac_pkg::ARB_FOREIGN;
      end
      bhac_pkg::ARB_FOREIGN: begin
        if (!ack_s) begin
          s_d.arb = bhac_pkg::ARB_OWN;
        end else if (req_s) begin
          s_d.arb = bhac_pkg::ARB_GRANT;
        end
      end
    endcase

    s_d.grant = (s_d.arb == bhac_pkg::ARB_GRANT) || (s_d.arb == bhac_pkg::ARB_GRANT_HOLD);
    // float only once our own strobe is idle; held access values reappear on return
    s_d.addr_oe_n = (s_d.arb != bhac_pkg::ARB_OWN) && (s_d.bus != bhac_pkg::BUS_RUN);
    s_d.ctrl_oe_n = s_d.addr_oe_n;
    s_d.strobe_n = (s_d.bus != bhac_pkg::BUS_RUN);
    s_d.data_oe_n = !((s_d.bus == bhac_pkg::BUS_RUN) && !s_d.acc.rw);

    // status: level on double fault, short pulses otherwise
    if (s_q.stat_cnt != 2'h0) begin
      s_d.stat_cnt = s_q.stat_cnt - 2'h1;
    end else if ((status_len_i != 2'h0) && (status_len_i <= `BHAC_STAT_MAX)) begin
      s_d.stat_cnt = status_len_i;
    end
    s_d.status = s_d.dbl || (s_d.stat_cnt != 2'h0);

    // halt gates the bus and interrupt servicing; execution from caches needs no stall here
    s_d.nop_stall = nop_i && ((s_d.bus != bhac_pkg::BUS_IDLE && s_d.bus != bhac_pkg::BUS_HALTED)
                    || cyc_req_i);
    s_d.irq_ok = irq_pending_i && !s_d.dbl && (s_d.bus != bhac_pkg::BUS_HALTED)
                 && (s_d.bus != bhac_pkg::BUS_RETRY) && !halt_req_i;
    s_d.irq_pend = irq_pending_i;
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.bus <= bhac_pkg::BUS_IDLE;
      s_q.arb <= bhac_pkg::ARB_OWN;
      s_q.acc.addr <= `BHAC_RST_ADDR;
      s_q.acc.fc <= `BHAC_RST_FC;
      s_q.acc.size <= `BHAC_RST_SIZE;
      s_q.acc.rw <= 1'b1;
      s_q.acc.wdata <= `BHAC_RST_DATA;
      s_q.rdata <= `BHAC_RST_DATA;
      s_q.strobe_n <= 1'b1;
      s_q.data_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign cyc_done_o = s_q.done;
  assign cyc_err_o = s_q.err;
  assign cyc_rdata_o = s_q.rdata;
  assign nop_stall_o = s_q.nop_stall;
  assign status_o = s_q.status;
  assign irq_service_ok_o = s_q.irq_ok;
  assign interrupt_pending_out_o = s_q.irq_pend;
  assign addr_o = s_q.acc.addr;
  assign fc_o = s_q.acc.fc;
  assign size_o = s_q.acc.size;
  assign rw_o = s_q.acc.rw;
  assign addr_oe_n_o = s_q.addr_oe_n;
  assign address_strobe_n_o = s_q.strobe_n;
  assign locked_cycle_indicator_n_o = !s_q.lock;
  assign ctrl_oe_n_o = s_q.ctrl_oe_n;
  assign data_o = s_q.acc.wdata;
  assign data_oe_n_o = s_q.data_oe_n;
  assign bus_grant_out_o = s_q.grant;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  no_start_halt_a: assert property (
    (s_q.bus == bhac_pkg::BUS_IDLE) && halt_req_i |=> address_strobe_n_o)
    else $error("cycle started under halt");

  halt_no_end_a: assert property (
    (s_q.bus == bhac_pkg::BUS_RUN) && halt_req_i && !bus_fault_in_i && !term_ack_i
    |=> !address_strobe_n_o && !cyc_done_o)
    else $error("halt ended a cycle");

  retry_not_err_a: assert property (
    (s_q.bus == bhac_pkg::BUS_RUN) && bus_fault_in_i && halt_req_i && !core_reset_i
    |=> (s_q.bus == bhac_pkg::BUS_RETRY) && !cyc_err_o && $stable(addr_o))
    else $error("fault with halt not retried");

  halt_pins_a: assert property (
    (s_q.bus == bhac_pkg::BUS_HALTED) && !ctrl_oe_n_o
    |-> data_oe_n_o && address_strobe_n_o && !addr_oe_n_o)
    else $error("halted pin state wrong");

  halt_hold_a: assert property (
    (s_q.bus == bhac_pkg::BUS_HALTED) |=> $stable(addr_o) && $stable(fc_o) && $stable(rw_o))
    else $error("held address changed");

  foreign_float_a: assert property (
    (s_q.arb == bhac_pkg::ARB_FOREIGN) && address_strobe_n_o |-> addr_oe_n_o && ctrl_oe_n_o)
    else $error("pins driven under foreign master");

  no_irq_halt_a: assert property (
    (s_q.bus == bhac_pkg::BUS_HALTED) || s_q.dbl |-> !irq_service_ok_o)
    else $error("interrupt serviced while halted");

  double_fault_a: assert property (
    (s_q.bus == bhac_pkg::BUS_RUN) && bus_fault_in_i && !halt_req_i && exc_active_i
    && !core_reset_i ##1 !core_reset_i [*3] |-> status_o [*3])
    else $error("double fault status not held");

  dbl_sticky_a: assert property (
    s_q.dbl && !core_reset_i |=> s_q.dbl && address_strobe_n_o)
    else $error("double fault cleared without reset");

  grant_defer_a: assert property (
    (s_q.arb == bhac_pkg::ARB_OWN) && start_now |=> !bus_grant_out_o ##1 !address_strobe_n_o)
    else $error("grant before decided cycle began");

  lock_grant_a: assert property (
    s_q.lock && (s_q.arb == bhac_pkg::ARB_OWN) |=> !bus_grant_out_o)
    else $error("grant during locked sequence");

  grant_drop_a: assert property (
    (s_q.arb == bhac_pkg::ARB_GRANT_HOLD) && ack_s |=> !bus_grant_out_o [*2])
    else $error("grant not negated after acknowledge");

  sync_delay_a: assert property (
    ##2 1'b1 |-> s_q.sync2 == $past({bus_request_in_i, grant_acknowledge_in_i}, 2))
    else $error("synchroniser depth wrong");

  nop_stall_a: assert property (
    nop_i && (s_q.bus == bhac_pkg::BUS_RUN) && !term_ack_i && !bus_fault_in_i
    && !core_reset_i |=> nop_stall_o)
    else $error("no-operation did not stall");

endmodule

// ---- test/bhac_master_model.sv ----
`timescale 1ns/1ps

module bhac_master_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // bench control
  input wire logic want_i,
  input wire logic keep_i,
  // arbitration pins
  input wire logic bus_grant_out_i,
  input wire logic address_strobe_n_i,
  output logic bus_request_in_o,
  output logic grant_acknowledge_in_o
);
  logic [1:0] idle_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_q <= 2'h0;
      bus_request_in_o <= 1'b0;
      grant_acknowledge_in_o <= 1'b0;
    end else begin
      idle_q <= {idle_q[0], address_strobe_n_i};
      // keep_i stands for a second master still waiting on the shared line
      bus_request_in_o <= want_i & (~grant_acknowledge_in_o | keep_i);
      // strobe seen idle on two edges so a cycle just decided cannot collide
      if (want_i && bus_grant_out_i && &idle_q && !grant_acknowledge_in_o) begin
        grant_acknowledge_in_o <= 1'b1;
      end else if (!want_i) begin
        grant_acknowledge_in_o <= 1'b0;
      end
    end
  end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "bhac_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c) begin for (int k = 0; k < 40 && !(c); k++) begin \
  @(posedge sys_clk_i); #1; end `CHK(c, 1'b1) end

module tb;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic core_rst = 1'b0, req = 1'b0, rw = 1'b1, lck = 1'b0, exc = 1'b0;
  logic no_operation_instruction = 1'b0, irq = 1'b0, halt = 1'b0, fault = 1'b0, term = 1'b0, aerr = 1'b0;
  logic want = 1'b0, keep = 1'b0;
  logic [1:0] slen = 2'h0;
  logic [`BHAC_ADDR_W-1:0] addr = 32'h0, a_o;
  logic [`BHAC_DATA_W-1:0] din = 32'h0, rdata, d_o;
  logic done, err, stall, status, irq_ok, interrupt_pending_out, rwo, aoe_n, as_n, lock_n, coe_n, doe_n;
  logic br, ack, grant;
  logic [2:0] fc;
  logic [1:0] sz;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  bhac_bus_ctrl u_bhac_bus_ctrl (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .core_reset_i(core_rst), .cyc_req_i(req),
    .cyc_addr_i(addr), .cyc_fc_i(addr[2:0]), .cyc_size_i(addr[4:3]), .cyc_rw_i(rw),
    .cyc_locked_i(lck), .cyc_wdata_i(~addr), .cyc_done_o(done), .cyc_err_o(err),
    .cyc_rdata_o(rdata), .exc_active_i(exc), .addr_err_i(aerr), .nop_i(no_operation_instruction),
    .nop_stall_o(stall), .status_len_i(slen), .status_o(status), .irq_pending_i(irq),
    .irq_service_ok_o(irq_ok), .interrupt_pending_out_o(interrupt_pending_out), .halt_req_i(halt),
    .bus_fault_in_i(fault), .term_ack_i(term), .data_i(din), .addr_o(a_o), .fc_o(fc),
    .size_o(sz), .rw_o(rwo), .addr_oe_n_o(aoe_n), .address_strobe_n_o(as_n),
    .locked_cycle_indicator_n_o(lock_n), .ctrl_oe_n_o(coe_n), .data_o(d_o),
    .data_oe_n_o(doe_n), .bus_request_in_i(br), .grant_acknowledge_in_i(ack),
    .bus_grant_out_o(grant));

  bhac_master_model u_bhac_master_model (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .want_i(want), .keep_i(keep),
    .bus_grant_out_i(grant), .address_strobe_n_i(as_n), .bus_request_in_o(br),
    .grant_acknowledge_in_o(ack));

  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task start(input logic [31:0] a, input logic w);
    @(posedge sys_clk_i);
    req <= 1'b1;
    addr <= a;
    rw <= w;
    `WAIT(as_n === 1'b0)
    `CHK({a_o, fc, sz, rwo}, {a, a[2:0], a[4:3], w})
  endtask

  // request is kept up on a retry, since the same access must run again
  task fin(input logic t, input logic f);
    @(posedge sys_clk_i);
    term <= t;
    fault <= f;
    din <= addr ^ 32'h5a5a_0000;
    @(posedge sys_clk_i);
    term <= 1'b0;
    fault <= 1'b0;
    if (t || !halt) req <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task read_nop;
    start(32'h0000_1018, 1'b1);
    @(posedge sys_clk_i);
    no_operation_instruction <= 1'b1;
    tick(2);
    `CHK(stall, 1'b1)
    fin(1'b1, 1'b0);
    `CHK({done, rdata}, {1'b1, 32'h5a5a_1018})
    tick(2);
    `CHK(stall, 1'b0)
    @(posedge sys_clk_i);
    no_operation_instruction <= 1'b0;
  endtask

  task halt_arb;
    start(32'h0000_2004, 1'b0);
    `CHK({doe_n, d_o}, {1'b0, ~32'h0000_2004})
    @(posedge sys_clk_i);
    halt <= 1'b1;
    tick(4);
    `CHK(as_n, 1'b0)
    fin(1'b1, 1'b0);
    `CHK(done, 1'b1)
    @(posedge sys_clk_i);
    req <= 1'b1;
    addr <= 32'h0000_3008;
    irq <= 1'b1;
    tick(4);
    `CHK({as_n, doe_n, coe_n, a_o}, {3'b110, 32'h0000_2004})
    `CHK({irq_ok, interrupt_pending_out}, 2'b01)
    @(posedge sys_clk_i);
    want <= 1'b1;
    `WAIT(grant === 1'b1)
    `CHK({aoe_n, coe_n}, 2'b11)
    `WAIT(grant === 1'b0)
    @(posedge sys_clk_i);
    want <= 1'b0;
    `WAIT(aoe_n === 1'b0)
    `CHK({coe_n, as_n, a_o}, {2'b01, 32'h0000_2004})
    @(posedge sys_clk_i);
    halt <= 1'b0;
    irq <= 1'b0;
    start(32'h0000_3008, 1'b1);
    fin(1'b1, 1'b0);
  endtask

  task retry;
    start(32'h0000_4010, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_i);
      halt <= 1'b1;
      exc <= 1'b1;
      fin(1'b0, 1'b1);
      `CHK({err, done, as_n}, 3'b001)
      @(posedge sys_clk_i);
      halt <= 1'b0;
      `WAIT(as_n === 1'b0)
      `CHK(a_o, 32'h0000_4010)
    end
    `CHK(status, 1'b0)
    fin(1'b1, 1'b0);
    @(posedge sys_clk_i);
    exc <= 1'b0;
  endtask

  task dbl_fault;
    int n;
    n = 0;
    @(posedge sys_clk_i);
    slen <= 2'h2;
    @(posedge sys_clk_i);
    slen <= 2'h0;
    #1;
    // the pulse is already up one clock after the length is loaded
    repeat (6) begin
      n += status;
      tick(1);
    end
    `CHK(n, 2)
    start(32'h0000_5000, 1'b1);
    fin(1'b0, 1'b1);
    `CHK({err, status}, 2'b10)
    @(posedge sys_clk_i);
    exc <= 1'b1;
    start(32'h0000_6000, 1'b1);
    fin(1'b0, 1'b1);
    @(posedge sys_clk_i);
    req <= 1'b1;
    addr <= 32'h0000_7000;
    want <= 1'b1;
    tick(4);
    `CHK({status, as_n}, 2'b11)
    `WAIT(ack === 1'b1)
    @(posedge sys_clk_i);
    want <= 1'b0;
    `WAIT(aoe_n === 1'b0)
    `CHK(status, 1'b1)
    @(posedge sys_clk_i);
    core_rst <= 1'b1;
    exc <= 1'b0;
    @(posedge sys_clk_i);
    core_rst <= 1'b0;
    start(32'h0000_7000, 1'b1);
    `CHK(status, 1'b0)
    fin(1'b1, 1'b0);
    // an address error inside exception processing is a double fault too
    @(posedge sys_clk_i);
    exc <= 1'b1;
    aerr <= 1'b1;
    @(posedge sys_clk_i);
    aerr <= 1'b0;
    exc <= 1'b0;
    tick(2);
    `CHK(status, 1'b1)
    @(posedge sys_clk_i);
    core_rst <= 1'b1;
    @(posedge sys_clk_i);
    core_rst <= 1'b0;
    tick(2);
    `CHK(status, 1'b0)
  endtask

  task lock_arb;
    @(posedge sys_clk_i);
    lck <= 1'b1;
    keep <= 1'b1;
    start(32'h0000_8000, 1'b1);
    `CHK(lock_n, 1'b0)
    @(posedge sys_clk_i);
    want <= 1'b1;
    tick(6);
    `CHK(grant, 1'b0)
    fin(1'b1, 1'b0);
    @(posedge sys_clk_i);
    lck <= 1'b0;
    `WAIT(grant === 1'b1)
    `WAIT(ack === 1'b1)
    `WAIT(grant === 1'b0)
    `WAIT(grant === 1'b1)
    @(posedge sys_clk_i);
    want <= 1'b0;
    keep <= 1'b0;
    `WAIT(aoe_n === 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk_i = ~sys_clk_i;

  // the whole run is under two hundred cycles, so this only catches a hang
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done;
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    tick(2);
    read_nop;
    halt_arb;
    retry;
    dbl_fault;
    lock_arb;
    test_done;
  end
endmodule
